/* File: hdl/icd_chk_gen.sv */
// Parity and five-bit Hamming code generator for up to 20 bits.
// Assumes unused upper data bits are zero.
`timescale 1ns/1ps
module icd_chk_gen (
  icd_chk_if.gen ch // Data in, check bits out
);

  // ==================================================================
  // Code generation
  // Each data bit takes the next Hamming position that is not a power
  // of two; zero bits add nothing, so narrow data needs no special case.
  always_comb begin
    int j;
    logic [4:0] c;
    j = 0;
    c = 5'h00;
    for (int p = 3; p < 32; p++) begin
      if ((p & (p - 1)) != 0 && j < 20) begin
        if (ch.data[j]) begin
          c = c ^ 5'(p);
        end
        j = j + 1;
      end
    end
    ch.code = c;
    ch.par = ^ch.data; // Even parity bit
  end

endmodule // icd_chk_gen

/* File: hdl/icd_chk_if.sv */
// Carrier between a check-bit generator and its user.
// Assumes the user drives data and samples results combinationally.
`timescale 1ns/1ps
interface icd_chk_if;
  logic [19:0] data; // Protected data, zero-extended
  logic par; // Even parity over data
  logic [4:0] code; // Five-bit Hamming code over data

  modport gen (input data, output par, output code);
  modport use_side (output data, input par, input code);
endinterface

/* File: hdl/icd_consts.svh */
// Constants for the instruction cache diagnostic access block.
// Assumes the core CSR path delivers 12-bit CSR addresses.
//
// Functional notes
// - Outside debug mode, accesses trap as illegal.
// - Parity bit 1 covers instruction bits 31:16.
// - Parity bit 0 covers bits 15:0 or tag.
// - ECC: 9:5 upper code, 4:0 lower/tag.
// - Fetch path generates and checks check bits.
// - Trigger read loads both holding registers from array.
// - Trigger write of one stores both registers.
// - Trigger reads zero; bits 31:1 reserved.
// - Select: bit 24 array, 21:20 way, 15:2 index.
// - Content: instruction 31:0, or tag 31:12.
// - Tag access: LRU 6:4 shared, valid bit 0.
`ifndef ICD_CONSTS_SVH
`define ICD_CONSTS_SVH

// ====================================================================
// CSR addresses
`define ICD_CHECK_BITS_ADDR 12'h7CA
`define ICD_TRIGGER_ADDR 12'h7CB

// ====================================================================
// Field positions and masks
`define ICD_TRIG_GO_BIT 0
`define ICD_SEL_ARRAY_BIT 24
`define ICD_SEL_WAY_HI 21
`define ICD_SEL_WAY_LO 20
`define ICD_SEL_IDX_HI 15
`define ICD_SEL_IDX_LO 2
`define ICD_TAG_HI 31
`define ICD_TAG_LO 12
`define ICD_PAR_MASK 32'h0000_0003
`define ICD_ECC_MASK 32'h0000_03FF

// ====================================================================
// Reset values
`define ICD_CHECK_BITS_RST 32'h0000_0000

`endif

/* File: hdl/icd_diag_access.sv */
// Instruction cache diagnostic access and fetch check-bit logic.
// Assumes the core stalls the CSR op until csr_done_q, and the cache
// arrays answer a read with arr_rvalid some cycles after arr_req_q.
`timescale 1ns/1ps
`include "icd_consts.svh"
module icd_diag_access #(
  parameter bit USE_ECC = 1'b0 // Build choice: 0 parity, 1 ECC
) (
  input wire logic clock, // Core clock, 50 MHz
  input wire logic rst_n, // Async reset, active low
  input wire logic debug_mode, // Core is in debug mode
  input wire logic csr_valid, // CSR access request pulse
  input wire logic csr_write, // Request is a write
  input wire logic [11:0] csr_addr, // CSR address
  input wire logic [31:0] csr_wdata, // CSR write data
  input wire logic [31:0] sel_loc, // Location-select register value
  input wire logic [31:0] content_in, // Content holding register
  output logic csr_done_q, // Access answered pulse
  output logic csr_illegal_q, // Illegal instruction with done
  output logic [31:0] csr_rdata_q, // CSR read data
  output logic content_load_q, // Load content register pulse
  output logic [31:0] content_q, // Value for content register
  output logic arr_req_q, // Array access pulse
  output logic arr_we_q, // Array access is a write
  output logic arr_tag_sel_q, // 1 tag/status array, 0 data
  output logic [1:0] arr_way_q, // Way
  output logic [13:0] arr_index_q, // Index
  output logic [31:0] arr_wdata_q, // Content to write
  output logic [9:0] arr_wcheck_q, // Check bits to write
  input wire logic arr_rvalid, // Array read data valid
  input wire logic [31:0] arr_rdata, // Array read content
  input wire logic [9:0] arr_rcheck, // Array read check bits
  input wire logic fill_valid, // Fetch fill data valid
  input wire logic [31:0] fill_data, // Fill instruction word
  input wire logic [19:0] fill_tag, // Fill tag
  output logic [9:0] fill_data_check_q, // Generated data check bits
  output logic [4:0] fill_tag_check_q, // Generated tag check bits
  input wire logic rd_valid, // Fetch read valid
  input wire logic [31:0] rd_data, // Fetched instruction word
  input wire logic [9:0] rd_data_check, // Stored data check bits
  input wire logic [19:0] rd_tag, // Fetched tag
  input wire logic [4:0] rd_tag_check, // Stored tag check bits
  output logic data_err_q, // Data check mismatch pulse
  output logic tag_err_q // Tag check mismatch pulse
);

  // ==================================================================
  // Check-bit generators: fill lo/hi/tag, then read lo/hi/tag
  icd_chk_if lane [6] ();
  logic [19:0] lane_data [6]; // Zero-extended lane data
  assign lane_data[0] = {4'h0, fill_data[15:0]};
  assign lane_data[1] = {4'h0, fill_data[31:16]};
  assign lane_data[2] = fill_tag;
  assign lane_data[3] = {4'h0, rd_data[15:0]};
  assign lane_data[4] = {4'h0, rd_data[31:16]};
  assign lane_data[5] = rd_tag;

  for (genvar g = 0; g < 6; g++) begin : g_lane
    assign lane[g].data = lane_data[g];
    icd_chk_gen u_gen (
      .ch(lane[g])
    );
  end

  logic [9:0] fill_dchk; // Layout of fill data check bits
  logic [4:0] fill_tchk; // Layout of fill tag check bits
  logic [9:0] rd_dchk; // Recomputed read data check bits
  logic [4:0] rd_tchk; // Recomputed read tag check bits

  // Parity or ECC layout, fixed at build time
  always_comb begin
    if (USE_ECC) begin
      fill_dchk = {lane[1].code, lane[0].code};
      fill_tchk = lane[2].code;
      rd_dchk = {lane[4].code, lane[3].code};
      rd_tchk = lane[5].code;
    end else begin
      fill_dchk = {8'h00, lane[1].par, lane[0].par};
      fill_tchk = {4'h0, lane[2].par};
      rd_dchk = {8'h00, lane[4].par, lane[3].par};
      rd_tchk = {4'h0, lane[5].par};
    end
  end

  // ==================================================================
  // Fetch path check bits and error flags
  logic [9:0] fill_data_check_d; // Next data check bits
  logic [4:0] fill_tag_check_d; // Next tag check bits
  logic data_err_d; // Next data error pulse
  logic tag_err_d; // Next tag error pulse

  // Generate on fill, compare on read
  always_comb begin
    fill_data_check_d = fill_data_check_q;
    fill_tag_check_d = fill_tag_check_q;
    if (fill_valid) begin
      fill_data_check_d = fill_dchk;
      fill_tag_check_d = fill_tchk;
    end
    data_err_d = rd_valid && (rd_dchk != rd_data_check);
    tag_err_d = rd_valid && (rd_tchk != rd_tag_check);
  end

  // Fetch path registers
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      fill_data_check_q <= 10'h000;
      fill_tag_check_q <= 5'h00;
      data_err_q <= 1'b0;
      tag_err_q <= 1'b0;
    end else begin
      fill_data_check_q <= fill_data_check_d;
      fill_tag_check_q <= fill_tag_check_d;
      data_err_q <= data_err_d;
      tag_err_q <= tag_err_d;
    end
  end

  // ==================================================================
  // Diagnostic CSR sequencer
  localparam logic [31:0] CHK_MASK =
    USE_ECC ? `ICD_ECC_MASK : `ICD_PAR_MASK;

  icd_pkg::icd_state_t state_q, state_d; // Sequencer state
  logic [31:0] check_bits_q, check_bits_d; // Check-bit holding register
  logic csr_done_d, csr_illegal_d, content_load_d;
  logic [31:0] csr_rdata_d, content_d, arr_wdata_d;
  logic arr_req_d, arr_we_d, arr_tag_sel_d;
  logic [1:0] arr_way_d;
  logic [13:0] arr_index_d;
  logic [9:0] arr_wcheck_d;
  logic hit_chk, hit_trig; // Address decode

  assign hit_chk = csr_addr == `ICD_CHECK_BITS_ADDR;
  assign hit_trig = csr_addr == `ICD_TRIGGER_ADDR;

  // Next-state and register-file logic
  always_comb begin
    state_d = state_q;
    check_bits_d = check_bits_q;
    csr_done_d = 1'b0;
    csr_illegal_d = 1'b0;
    csr_rdata_d = csr_rdata_q;
    content_load_d = 1'b0;
    content_d = content_q;
    arr_req_d = 1'b0;
    arr_we_d = arr_we_q;
    arr_tag_sel_d = arr_tag_sel_q;
    arr_way_d = arr_way_q;
    arr_index_d = arr_index_q;
    arr_wdata_d = arr_wdata_q;
    arr_wcheck_d = arr_wcheck_q;
    unique case (state_q)
      icd_pkg::ICD_IDLE: begin
        if (csr_valid && (hit_chk || hit_trig)) begin
          csr_done_d = 1'b1;
          csr_rdata_d = 32'h0000_0000;
          if (!debug_mode) begin
            csr_illegal_d = 1'b1;
          end else if (hit_chk) begin
            if (csr_write) begin
              check_bits_d = csr_wdata & CHK_MASK;
            end else begin
              csr_rdata_d = check_bits_q;
            end
          end else begin
            // Location select drives every trigger access
            arr_tag_sel_d = sel_loc[`ICD_SEL_ARRAY_BIT];
            arr_way_d = sel_loc[`ICD_SEL_WAY_HI:`ICD_SEL_WAY_LO];
            arr_index_d = sel_loc[`ICD_SEL_IDX_HI:`ICD_SEL_IDX_LO];
            if (csr_write) begin
              // Go bit only; the rest of the word is reserved
              if (csr_wdata[`ICD_TRIG_GO_BIT]) begin
                arr_req_d = 1'b1;
                arr_we_d = 1'b1;
                arr_wdata_d = content_in;
                // Stored as loaded; no regeneration, so errors inject
                arr_wcheck_d = check_bits_q[9:0];
              end
            end else begin
              // Trigger read waits for the array before answering
              csr_done_d = 1'b0;
              arr_req_d = 1'b1;
              arr_we_d = 1'b0;
              state_d = icd_pkg::ICD_RD_WAIT;
            end
          end
        end
      end
      icd_pkg::ICD_RD_WAIT: begin
        if (arr_rvalid) begin
          content_load_d = 1'b1;
          content_d = arr_rdata;
          check_bits_d = {22'h0, arr_rcheck} & CHK_MASK;
          csr_done_d = 1'b1;
          csr_rdata_d = 32'h0000_0000;
          state_d = icd_pkg::ICD_IDLE;
        end
      end
      default: begin
        state_d = icd_pkg::ICD_IDLE; // Recover from illegal code
      end
    endcase
  end

  // Sequencer registers
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= icd_pkg::ICD_IDLE;
      check_bits_q <= `ICD_CHECK_BITS_RST;
      csr_done_q <= 1'b0;
      csr_illegal_q <= 1'b0;
      csr_rdata_q <= 32'h0000_0000;
      content_load_q <= 1'b0;
      content_q <= 32'h0000_0000;
      arr_req_q <= 1'b0;
      arr_we_q <= 1'b0;
      arr_tag_sel_q <= 1'b0;
      arr_way_q <= 2'h0;
      arr_index_q <= 14'h0000;
      arr_wdata_q <= 32'h0000_0000;
      arr_wcheck_q <= 10'h000;
    end else begin
      state_q <= state_d;
      check_bits_q <= check_bits_d;
      csr_done_q <= csr_done_d;
      csr_illegal_q <= csr_illegal_d;
      csr_rdata_q <= csr_rdata_d;
      content_load_q <= content_load_d;
      content_q <= content_d;
      arr_req_q <= arr_req_d;
      arr_we_q <= arr_we_d;
      arr_tag_sel_q <= arr_tag_sel_d;
      arr_way_q <= arr_way_d;
      arr_index_q <= arr_index_d;
      arr_wdata_q <= arr_wdata_d;
      arr_wcheck_q <= arr_wcheck_d;
    end
  end

  // ==================================================================
  // Assertions
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  logic idle_hit; // Accepted access to our CSRs
  assign idle_hit = csr_valid && (hit_chk || hit_trig) &&
                    state_q == icd_pkg::ICD_IDLE;

  a_illegal_trap: assert property (
    idle_hit && !debug_mode |=> csr_illegal_q && csr_done_q && !arr_req_q)
    else $error("Non-debug access did not trap");
  a_parity_upper: assert property (
    !USE_ECC && fill_valid |=>
      fill_data_check_q[1] == ^$past(fill_data[31:16]))
    else $error("Upper parity wrong");
  a_parity_lower: assert property (
    !USE_ECC && fill_valid |=>
      fill_data_check_q[0] == ^$past(fill_data[15:0]) &&
      fill_tag_check_q[0] == ^$past(fill_tag))
    else $error("Lower or tag parity wrong");
  a_resv_zero: assert property (
    (check_bits_q & ~CHK_MASK) == 32'h0000_0000)
    else $error("Reserved check bits set");
  a_fetch_err: assert property (
    !USE_ECC && rd_valid && (^rd_data[15:0] != rd_data_check[0]) |=>
      data_err_q)
    else $error("Fetch parity error missed");
  a_read_load: assert property (
    idle_hit && debug_mode && hit_trig && !csr_write |=>
      arr_req_q && !arr_we_q && !csr_done_q)
    else $error("Trigger read did not start array read");
  a_read_done: assert property (
    state_q == icd_pkg::ICD_RD_WAIT && arr_rvalid |=>
      content_load_q && content_q == $past(arr_rdata) && csr_done_q)
    else $error("Array read data not loaded");
  a_write_go: assert property (
    idle_hit && debug_mode && hit_trig && csr_write |=>
      arr_req_q == $past(csr_wdata[0]) &&
      (!arr_req_q || arr_wcheck_q == $past(check_bits_q[9:0])))
    else $error("Trigger write wrong");
  a_trig_zero: assert property (
    idle_hit && hit_trig |=> csr_rdata_q == 32'h0000_0000)
    else $error("Trigger did not read zero");
  a_select_pass: assert property (
    idle_hit && debug_mode && hit_trig |=>
      arr_tag_sel_q == $past(sel_loc[24]) &&
      arr_index_q == $past(sel_loc[15:2]))
    else $error("Location select not applied");

endmodule // icd_diag_access

/* File: hdl/icd_pkg.sv */
// Types shared by the diagnostic access block.
// Assumes nothing beyond a SystemVerilog compiler.
package icd_pkg;

  // ==================================================================
  // Diagnostic sequencer states, one-hot
  typedef enum logic [1:0] {
    ICD_IDLE    = 2'b01, // Ready for a CSR access
    ICD_RD_WAIT = 2'b10  // Array read in flight
  } icd_state_t;

endpackage

/* File: tb/testbench.sv */
// Self-checking bench for the icache diagnostic access block.
// Assumes the parity build, with an ECC build beside it for the layout;
// the bench plays core, debugger and arrays.
`timescale 1ns/1ps
module testbench;
  // ==================================================================
  // Table rows and bench signals
  typedef struct {
    logic we; // Write, else read
    logic [11:0] a; // CSR address
    logic [31:0] wd; // Write data
    logic [31:0] er; // Expected read data
    logic ereq; // Array access expected
  } icd_row_t;
  logic clock = 1'b0, rst_n = 1'b0, debug_mode = 1'b1; // Core side
  logic csr_valid = 1'b0, csr_write = 1'b0, arr_rvalid = 1'b0; // Strobes
  logic fill_valid = 1'b0, rd_valid = 1'b0; // Fetch strobes
  logic [11:0] csr_addr = 12'h000; // CSR address
  logic [31:0] csr_wdata = 32'h0, sel_loc = 32'h0, content_in = 32'h0;
  logic [31:0] arr_rdata = 32'h0, fill_data = 32'h0, rd_data = 32'h0;
  logic [9:0] arr_rcheck = 10'h000, rd_data_check = 10'h000;
  logic [19:0] fill_tag = 20'h00000, rd_tag = 20'h00000; // Tags
  logic [4:0] rd_tag_check = 5'h00; // Stored tag bits
  logic csr_done_q, csr_illegal_q, content_load_q, arr_req_q, arr_we_q;
  logic arr_tag_sel_q, data_err_q, tag_err_q; // Outputs
  logic [31:0] csr_rdata_q, content_q, arr_wdata_q; // Outputs
  logic [1:0] arr_way_q; // Way out
  logic [13:0] arr_index_q; // Index out
  logic [9:0] arr_wcheck_q, fill_data_check_q; // Check bits out
  logic [4:0] fill_tag_check_q; // Tag check out
  logic done_s, ill_s, req_s, load_s; // Captured at answer; req_s the cycle after the request
  logic [31:0] rd_s, cont_s; // Captured at answer
  int n_mismatch = 0, check_count = 0, cycles = 0; // Bookkeeping
  icd_row_t rows [7]; // Ordinary cases

  icd_diag_access #(.USE_ECC(1'b0)) i_icd_diag_access (
    .clock(clock), .rst_n(rst_n), .debug_mode(debug_mode),
    .csr_valid(csr_valid), .csr_write(csr_write), .csr_addr(csr_addr),
    .csr_wdata(csr_wdata), .sel_loc(sel_loc), .content_in(content_in),
    .csr_done_q(csr_done_q), .csr_illegal_q(csr_illegal_q),
    .csr_rdata_q(csr_rdata_q), .content_load_q(content_load_q),
    .content_q(content_q), .arr_req_q(arr_req_q), .arr_we_q(arr_we_q),
    .arr_tag_sel_q(arr_tag_sel_q), .arr_way_q(arr_way_q),
    .arr_index_q(arr_index_q), .arr_wdata_q(arr_wdata_q),
    .arr_wcheck_q(arr_wcheck_q), .arr_rvalid(arr_rvalid),
    .arr_rdata(arr_rdata), .arr_rcheck(arr_rcheck),
    .fill_valid(fill_valid), .fill_data(fill_data), .fill_tag(fill_tag),
    .fill_data_check_q(fill_data_check_q),
    .fill_tag_check_q(fill_tag_check_q), .rd_valid(rd_valid),
    .rd_data(rd_data), .rd_data_check(rd_data_check), .rd_tag(rd_tag),
    .rd_tag_check(rd_tag_check), .data_err_q(data_err_q),
    .tag_err_q(tag_err_q)
  );

  // Second build in the ECC layout, fed the same stimulus; only its
  // read data and fill codes are compared, the rest stays open
  logic [31:0] e_rdata; // ECC build read data
  logic [9:0] e_dchk; // ECC build fill data code
  logic [4:0] e_tchk; // ECC build fill tag code
  if (1) begin : g_ecc
    icd_diag_access #(.USE_ECC(1'b1)) i_icd_diag_access (
      .clock(clock), .rst_n(rst_n), .debug_mode(debug_mode),
      .csr_valid(csr_valid), .csr_write(csr_write), .csr_addr(csr_addr),
      .csr_wdata(csr_wdata), .sel_loc(sel_loc), .content_in(content_in),
      .csr_done_q(), .csr_illegal_q(), .csr_rdata_q(e_rdata),
      .content_load_q(), .content_q(), .arr_req_q(), .arr_we_q(),
      .arr_tag_sel_q(), .arr_way_q(), .arr_index_q(), .arr_wdata_q(),
      .arr_wcheck_q(), .arr_rvalid(arr_rvalid), .arr_rdata(arr_rdata),
      .arr_rcheck(arr_rcheck), .fill_valid(fill_valid),
      .fill_data(fill_data), .fill_tag(fill_tag),
      .fill_data_check_q(e_dchk), .fill_tag_check_q(e_tchk),
      .rd_valid(rd_valid), .rd_data(rd_data),
      .rd_data_check(rd_data_check), .rd_tag(rd_tag),
      .rd_tag_check(rd_tag_check), .data_err_q(), .tag_err_q()
    );
  end

  // ==================================================================
  // Clock and hang guard
  always #10 clock = ~clock;
  // Whole run is well under a thousand cycles; 3000 means a hang
  always @(posedge clock) begin
    cycles = cycles + 1;
    if (cycles == 3000) begin
      n_mismatch = n_mismatch + 1;
      conclude();
    end
  end

  // ==================================================================
  // Shared tasks
  task automatic conclude();
    if (n_mismatch == 0 && check_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] g, e);
    check_count = check_count + 1;
    if (g !== e) begin
      n_mismatch = n_mismatch + 1;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask

  // One CSR access; answers an array read, then waits for the answer
  task automatic csr(input logic we, input logic [11:0] a,
                     input logic [31:0] wd);
    @(posedge clock);
    #1;
    csr_valid = 1'b1;
    csr_write = we;
    csr_addr = a;
    csr_wdata = wd;
    @(posedge clock);
    #1;
    csr_valid = 1'b0;
    req_s = arr_req_q;
    done_s = 1'b0;
    // Array answers a read one cycle after the request
    if (arr_req_q === 1'b1 && arr_we_q === 1'b0) begin
      arr_rvalid = 1'b1;
      @(posedge clock);
      #1;
      arr_rvalid = 1'b0;
    end
    for (int k = 0; k < 8; k++) begin
      if (csr_done_q === 1'b1) begin
        done_s = 1'b1;
        ill_s = csr_illegal_q;
        rd_s = csr_rdata_q;
        load_s = content_load_q;
        cont_s = content_q;
        break;
      end
      @(posedge clock);
      #1;
    end
  endtask

  // One fetch fill and read, checks seen one cycle later
  task automatic fetch(input logic [9:0] dc, input logic [4:0] tc);
    @(posedge clock);
    #1;
    fill_valid = 1'b1;
    rd_valid = 1'b1;
    rd_data_check = dc;
    rd_tag_check = tc;
    @(posedge clock);
    #1;
    fill_valid = 1'b0;
    rd_valid = 1'b0;
  endtask

  // ==================================================================
  // Main sequence
  initial begin
    rows[0] = '{1'b0, 12'h7CA, 32'h0, 32'h0, 1'b0};
    rows[1] = '{1'b1, 12'h7CA, 32'hFFFF_FFFF, 32'h0, 1'b0};
    rows[2] = '{1'b0, 12'h7CA, 32'h0, 32'h3, 1'b0};
    rows[3] = '{1'b1, 12'h7CA, 32'h0000_0001, 32'h0, 1'b0};
    rows[4] = '{1'b0, 12'h7CA, 32'h0, 32'h1, 1'b0};
    rows[5] = '{1'b1, 12'h7CB, 32'h0, 32'h0, 1'b0};
    rows[6] = '{1'b1, 12'h7CB, 32'hFFFF_FFFE, 32'h0, 1'b0};
    repeat (12) @(posedge clock);
    #1;
    rst_n = 1'b1;
    chk("rst_out", {csr_done_q, arr_req_q, data_err_q, tag_err_q}, 0);
    chk("rst_rd", csr_rdata_q, 0);
    // Masked check bits, and go writes that leave bit 0 clear
    foreach (rows[i]) begin
      csr(rows[i].we, rows[i].a, rows[i].wd);
      chk("done", {ill_s, done_s}, 32'h1);
      chk("arr_req", req_s, rows[i].ereq);
      if (!rows[i].we) chk("rdata", rd_s, rows[i].er);
    end
    // Array write to tag array, way 2, index 0x1234
    sel_loc = 32'h0120_48D0;
    content_in = 32'hA5A5_0F0F;
    csr(1'b1, 12'h7CA, 32'h2);
    csr(1'b1, 12'h7CB, 32'h1);
    chk("wr_req", {req_s, arr_we_q, arr_tag_sel_q}, 32'h7);
    chk("wr_loc", {arr_way_q, arr_index_q}, 32'h9234);
    chk("wr_data", arr_wdata_q, 32'hA5A5_0F0F);
    chk("wr_chk", arr_wcheck_q, 32'h2);
    chk("go_rd0", rd_s, 32'h0);
    // Array read from data array, way 1, top index
    sel_loc = 32'h0010_FFFC;
    arr_rdata = 32'hDEAD_BEEF;
    arr_rcheck = 10'h3FE;
    csr(1'b0, 12'h7CB, 32'h0);
    chk("rd_req", {req_s, arr_we_q, arr_tag_sel_q}, 32'h4);
    chk("rd_loc", {arr_way_q, arr_index_q}, 32'h7FFF);
    chk("rd_load", {load_s, done_s}, 32'h3);
    chk("rd_cont", cont_s, 32'hDEAD_BEEF);
    chk("go_rd", rd_s, 32'h0);
    // Array lines released: show the inverse, not the old value
    arr_rdata = 32'h2152_4110;
    arr_rcheck = 10'h001;
    csr(1'b0, 12'h7CA, 32'h0);
    chk("rd_chk", rd_s, 32'h2);
    // Outside debug mode: trap, no array access, no state change
    debug_mode = 1'b0;
    csr(1'b1, 12'h7CA, 32'h1);
    chk("ill_wr", {ill_s, done_s, req_s}, 32'h6);
    csr(1'b0, 12'h7CB, 32'h0);
    chk("ill_go", {ill_s, done_s, req_s}, 32'h6);
    debug_mode = 1'b1;
    csr(1'b0, 12'h7CA, 32'h0);
    chk("kept", rd_s, 32'h2);
    chk("ecc_kept", e_rdata, 32'h3FE);
    // Fetch: hi parity 1, lo parity 0, tag parity 1
    fill_data = 32'h0001_0003;
    fill_tag = 20'h00007;
    rd_data = 32'h0001_0003;
    rd_tag = 20'h00007;
    fetch(10'h001, 5'h01);
    chk("fill_par",
        {fill_data_check_q[1:0], fill_tag_check_q[0]}, 5);
    // Codes: lower half 0x0003 gives 6, upper 0x0001 gives 3, tag 0
    chk("ecc_fill", {e_dchk, e_tchk}, 32'h0CC0);
    chk("err_dat", {data_err_q, tag_err_q}, 32'h2);
    fetch(10'h002, 5'h00);
    chk("err_tag", {data_err_q, tag_err_q}, 32'h1);
    // Reset in mid-run clears outputs and the check-bit register
    rst_n = 1'b0;
    @(posedge clock);
    #1;
    chk("rst_mid", {csr_done_q, arr_req_q, fill_data_check_q}, 0);
    rst_n = 1'b1;
    csr(1'b0, 12'h7CA, 32'h0);
    chk("rst_chk", rd_s, 32'h0);
    conclude();
  end
endmodule // testbench
